// >>> inc/cts_pkg.sv
package cts_pkg;

    // =====================================================================
    // Clock and timing
    // =====================================================================
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned RELAX_MS      = 32;
    localparam int unsigned RELAX_TICKS   = RELAX_MS / TICK_MS;
    localparam int unsigned MS_PER_MIN    = 60_000;
    localparam int unsigned PRE_MIN_0     = 40;
    localparam int unsigned PRE_MIN_1     = 60;
    localparam int unsigned PRE_MIN_2     = 80;
    localparam int unsigned TOT_HRS_0     = 3;
    localparam int unsigned TOT_HRS_1     = 4;
    localparam int unsigned TOT_HRS_2     = 5;
    localparam int unsigned TIMER_W       = 25;

    // =====================================================================
    // Timeout select codes and reset values
    // =====================================================================
    localparam logic [1:0] SEL_DISABLED   = 2'h3;
    localparam logic       TEMP_OK_RESET  = 1'h1;

    // =====================================================================
    // Charge states
    // =====================================================================
    typedef enum logic [2:0] {
        CTS_SUSPEND   = 3'b000,
        CTS_PRECOND   = 3'b001,
        CTS_FAST      = 3'b010,
        CTS_TOPOFF    = 3'b011,
        CTS_EOC       = 3'b100,
        CTS_TEMPFAULT = 3'b101,
        CTS_TIMEFAULT = 3'b110
    } cts_state_e;

endpackage

// >>> inc/cts_tick_if.sv
`timescale 1ns/1ps
interface cts_tick_if;
    logic tick;
    logic [15:0] stretchNum;
    modport source (output tick, input stretchNum);
    modport sink   (input tick, output stretchNum);
endinterface

// >>> verilog/cts_tick_gen.sv
`timescale 1ns/1ps
module cts_tick_gen #(
    parameter int unsigned TICK_CYCLES = cts_pkg::TICK_CYCLES
) (
    input  wire logic   core_clk,
    input  wire logic   rst_b,
    cts_tick_if.source  tb
);
    // =====================================================================
    // Prescaler with proportional stretch
    // =====================================================================
    // stretchNum is current ratio in 1/65536 units; a fractional accumulator
    // issues ticks at that fraction of the nominal rate.
    typedef struct packed {
        logic [31:0] div;
        logic [16:0] acc;
        logic        tick;
    } cts_tick_s;

    cts_tick_s st;
    cts_tick_s next_st;

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.div >= TICK_CYCLES - 1) begin
            next_st.div = 32'h0;
            if ({1'b0, st.acc[15:0]} + {1'b0, tb.stretchNum} >= 17'h10000 ||
                tb.stretchNum == 16'hffff) begin
                next_st.tick = 1'b1;
            end
            next_st.acc = {1'b0, st.acc[15:0]} + {1'b0, tb.stretchNum};
        end else begin
            next_st.div = st.div + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tb.tick = st.tick;
endmodule

// >>> verilog/cts_charger_supervisor.sv
`timescale 1ns/1ps
// What this block does
// - Total limit is 3, 4 or 5 hours for codes 00, 01, 10; code 11 disables it.
// - Status pin sinks in precondition, fast and top-off, and floats in every other state.
// - Charging is suspended while the thermistor sense says temperature is out of window.
// - With leave enable set, leaving the valid range raises the temperature flag.
// - With enter enable set, returning into the valid range raises the temperature flag.
// - The live temperature bit is 1 in range and 0 out of range.
// - The temperature flag reads 1 after an event and clears on a read, unless a new event lands in the same cycle.
// - Precondition timer expiry before the threshold is passed goes to timeout fault.
// - Total timer expiry in fast charge goes to end-of-charge and restarts after 32 ms.
// - Under thermal regulation both timers slow in proportion to the current reduction.
module cts_charger_supervisor #(
    parameter int unsigned TICK_CYCLES = cts_pkg::TICK_CYCLES,
    parameter int unsigned RELAX_TICKS = cts_pkg::RELAX_TICKS,
    parameter int unsigned MS_PER_MIN  = cts_pkg::MS_PER_MIN
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  precond_timeout_sel,
    input  wire logic [1:0]  total_timeout_sel,
    input  wire logic        thermistor_sense_hot,
    input  wire logic        thermistor_sense_cold,
    input  wire logic        temp_leave_irq_en,
    input  wire logic        temp_enter_irq_en,
    input  wire logic        temp_irq_flag_rd,
    input  wire logic        battery_present,
    input  wire logic        charger_input_supply_ok,
    input  wire logic        suspend_req,
    input  wire logic        vbat_above_precond,
    input  wire logic        vbat_at_term,
    input  wire logic        vbat_recharge,
    input  wire logic        eoc_current,
    input  wire logic [15:0] current_ratio,
    output logic             charge_indicator_n_oe_b,
    output logic             charge_indicator_n_out,
    output logic             temp_in_range,
    output logic             temp_irq_flag,
    output logic [2:0]       charge_state,
    output logic             precond_expired,
    output logic             total_expired
);
    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        cts_pkg::cts_state_e     state;
        logic [cts_pkg::TIMER_W-1:0] preCnt;
        logic [cts_pkg::TIMER_W-1:0] totCnt;
        logic [5:0]              relaxCnt;
        logic                    relaxing;
        logic                    tempOk;
        logic                    tempFlag;
        logic                    preExp;
        logic                    totExp;
    } cts_sup_s;

    cts_sup_s st;
    cts_sup_s next_st;

    cts_tick_if tickBus();

    cts_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tb       (tickBus.source)
    );

    // Ratio 0 would freeze the timers forever; treat it as full rate instead.
    assign tickBus.stretchNum = (current_ratio == 16'h0) ? 16'hffff : current_ratio;

    // =====================================================================
    // Timeout decode
    // =====================================================================
    function automatic logic [cts_pkg::TIMER_W-1:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_limit = cts_pkg::TIMER_W'(cts_pkg::PRE_MIN_0 * MS_PER_MIN);
            2'h1:    pre_limit = cts_pkg::TIMER_W'(cts_pkg::PRE_MIN_1 * MS_PER_MIN);
            2'h2:    pre_limit = cts_pkg::TIMER_W'(cts_pkg::PRE_MIN_2 * MS_PER_MIN);
            default: pre_limit = '1;
        endcase
    endfunction

    function automatic logic [cts_pkg::TIMER_W-1:0] tot_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    tot_limit = cts_pkg::TIMER_W'(cts_pkg::TOT_HRS_0 * 60 * MS_PER_MIN);
            2'h1:    tot_limit = cts_pkg::TIMER_W'(cts_pkg::TOT_HRS_1 * 60 * MS_PER_MIN);
            2'h2:    tot_limit = cts_pkg::TIMER_W'(cts_pkg::TOT_HRS_2 * 60 * MS_PER_MIN);
            default: tot_limit = '1;
        endcase
    endfunction

    logic tempNow;
    logic supplyOk;
    logic preHit;
    logic totHit;

    assign tempNow  = !thermistor_sense_hot && !thermistor_sense_cold;
    assign supplyOk = battery_present && charger_input_supply_ok && !suspend_req;
    assign preHit   = (precond_timeout_sel != cts_pkg::SEL_DISABLED) &&
                      (st.preCnt >= pre_limit(precond_timeout_sel));
    assign totHit   = (total_timeout_sel != cts_pkg::SEL_DISABLED) &&
                      (st.totCnt >= tot_limit(total_timeout_sel));

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        next_st        = st;
        next_st.tempOk = tempNow;
        if (tickBus.tick) begin
            if (st.state == cts_pkg::CTS_PRECOND && !preHit) begin
                next_st.preCnt = st.preCnt + 1'b1;
            end
            if ((st.state == cts_pkg::CTS_FAST || st.state == cts_pkg::CTS_TOPOFF) && !totHit) begin
                next_st.totCnt = st.totCnt + 1'b1;
            end
            if (st.relaxing) begin
                next_st.relaxCnt = st.relaxCnt + 1'b1;
            end
        end
        // Read clears, but a new event in the same cycle keeps the flag set.
        if (temp_irq_flag_rd) begin
            next_st.tempFlag = 1'b0;
        end
        if ((st.tempOk && !tempNow && temp_leave_irq_en) ||
            (!st.tempOk && tempNow && temp_enter_irq_en)) begin
            next_st.tempFlag = 1'b1;
        end

        case (st.state)
            cts_pkg::CTS_SUSPEND: begin
                if (supplyOk) begin
                    next_st.state  = cts_pkg::CTS_PRECOND;
                    next_st.preCnt = '0;
                    next_st.totCnt = '0;
                end
            end
            cts_pkg::CTS_PRECOND: begin
                if (vbat_above_precond) begin
                    next_st.state = cts_pkg::CTS_FAST;
                end else if (preHit) begin
                    next_st.state  = cts_pkg::CTS_TIMEFAULT;
                    next_st.preExp = 1'b1;
                end
            end
            cts_pkg::CTS_FAST: begin
                if (totHit) begin
                    next_st.state    = cts_pkg::CTS_EOC;
                    next_st.relaxing = 1'b1;
                    next_st.relaxCnt = '0;
                    next_st.totExp   = 1'b1;
                end else if (vbat_at_term) begin
                    next_st.state = cts_pkg::CTS_TOPOFF;
                end
            end
            cts_pkg::CTS_TOPOFF: begin
                if (eoc_current || totHit) begin
                    next_st.state  = cts_pkg::CTS_EOC;
                    next_st.totExp = totHit;
                end
            end
            cts_pkg::CTS_EOC: begin
                if ((st.relaxing && st.relaxCnt >= 6'(RELAX_TICKS)) || vbat_recharge) begin
                    next_st.state    = cts_pkg::CTS_PRECOND;
                    next_st.relaxing = 1'b0;
                    next_st.preCnt   = '0;
                    next_st.totCnt   = '0;
                    next_st.totExp   = 1'b0;
                end
            end
            cts_pkg::CTS_TEMPFAULT: begin
                if (tempNow) begin
                    next_st.state  = cts_pkg::CTS_PRECOND;
                    next_st.preCnt = '0;
                    next_st.totCnt = '0;
                end
            end
            cts_pkg::CTS_TIMEFAULT: begin
                // Held until supply or battery cycles through suspend.
            end
            default: next_st.state = cts_pkg::CTS_SUSPEND;
        endcase

        // Supply loss overrides every state; temperature overrides every state except timeout fault
        if (!supplyOk) begin
            next_st.state    = cts_pkg::CTS_SUSPEND;
            next_st.relaxing = 1'b0;
            next_st.preExp   = 1'b0;
            next_st.totExp   = 1'b0;
        end else if (!tempNow && st.state != cts_pkg::CTS_TIMEFAULT) begin
            // Taken from suspend as well, so no charging state is entered out of window
            next_st.state    = cts_pkg::CTS_TEMPFAULT;
            next_st.relaxing = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st        <= '0;
            st.state  <= cts_pkg::CTS_SUSPEND;
            st.tempOk <= cts_pkg::TEMP_OK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign charge_indicator_n_out  = 1'b0;
    assign charge_indicator_n_oe_b = !(st.state == cts_pkg::CTS_PRECOND ||
                                       st.state == cts_pkg::CTS_FAST ||
                                       st.state == cts_pkg::CTS_TOPOFF);
    assign temp_in_range   = st.tempOk;
    assign temp_irq_flag   = st.tempFlag;
    assign charge_state    = st.state;
    assign precond_expired = st.preExp;
    assign total_expired   = st.totExp;
endmodule

// >>> tb/cts_checker_assertions.sv
`timescale 1ns/1ps
module cts_checker (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       thermistor_sense_hot,
    input wire logic       thermistor_sense_cold,
    input wire logic       temp_leave_irq_en,
    input wire logic       temp_enter_irq_en,
    input wire logic       temp_irq_flag_rd,
    input wire logic       charge_indicator_n_oe_b,
    input wire logic       charge_indicator_n_out,
    input wire logic       temp_in_range,
    input wire logic       temp_irq_flag,
    input wire logic [2:0] charge_state
);
    // ==========
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_sink_when_active: assert property (charge_indicator_n_oe_b ==
        !(charge_state inside {3'h1, 3'h2, 3'h3})) else $error("indicator enable wrong");
    a_pin_low_only: assert property (charge_indicator_n_out == 1'b0)
        else $error("indicator pin not low");
    a_range_live: assert property (temp_in_range ==
        !($past(thermistor_sense_hot) || $past(thermistor_sense_cold))) else $error("range bit");
    a_hot_cold_stop: assert property (!temp_in_range |->
        charge_state inside {3'h0, 3'h5, 3'h6}) else $error("charging while out of range");
    a_leave_sets: assert property ($fell(temp_in_range) && $past(temp_leave_irq_en)
        |-> temp_irq_flag) else $error("leave event lost");
    a_enter_sets: assert property ($rose(temp_in_range) && $past(temp_enter_irq_en)
        |-> temp_irq_flag) else $error("enter event lost");
    a_flag_has_cause: assert property ($rose(temp_irq_flag) |->
        ($fell(temp_in_range) && $past(temp_leave_irq_en)) ||
        ($rose(temp_in_range) && $past(temp_enter_irq_en))) else $error("flag without cause");
    a_read_clears: assert property ($past(temp_irq_flag_rd) && $stable(temp_in_range)
        |-> !temp_irq_flag) else $error("flag not cleared");
    a_flag_sticks: assert property (temp_irq_flag && !temp_irq_flag_rd |=> temp_irq_flag)
        else $error("flag dropped");
endmodule

bind cts_charger_supervisor cts_checker u_chk (.core_clk, .rst_b, .thermistor_sense_hot,
    .thermistor_sense_cold, .temp_leave_irq_en, .temp_enter_irq_en, .temp_irq_flag_rd,
    .charge_indicator_n_oe_b, .charge_indicator_n_out, .temp_in_range, .temp_irq_flag,
    .charge_state);

// >>> tb/cts_host_model.sv
`timescale 1ns/1ps
module cts_host_model (
    input wire logic core_clk,
    input wire logic temp_irq_flag,
    output logic     temp_irq_flag_rd
);
    initial temp_irq_flag_rd = 1'b0;
    // Value taken while the read stands; the clear lands at the closing edge
    task automatic read_flag(output logic v);
        @(posedge core_clk);
        temp_irq_flag_rd <= 1'b1;
        #1 v = temp_irq_flag;
        @(posedge core_clk);
        temp_irq_flag_rd <= 1'b0;
    endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    // Short tick and minute keep the hour-long limits to at most 1200 cycles
    localparam int TC  = 2;
    localparam int MPM = 2;
    localparam int RT  = 4;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  preSel = 2'h3;
    logic [1:0]  totSel = 2'h3;
    logic        hot = 1'b0;
    logic        cold = 1'b0;
    logic        leaveEn = 1'b0;
    logic        enterEn = 1'b0;
    logic        susp = 1'b1;
    logic        aboveP = 1'b0;
    logic        atTerm = 1'b0;
    logic        eocCur = 1'b0;
    logic        rechg = 1'b0;
    logic [15:0] ratio = 16'h0;
    logic        rd, oeB, pinOut, inRange, flag, preExp, totExp;
    logic [2:0]  state;
    int          fails = 0;
    int          checked = 0;

    always #50 core_clk = ~core_clk;

    cts_charger_supervisor #(.TICK_CYCLES(TC), .RELAX_TICKS(RT), .MS_PER_MIN(MPM)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .precond_timeout_sel(preSel),
        .total_timeout_sel(totSel), .thermistor_sense_hot(hot), .thermistor_sense_cold(cold),
        .temp_leave_irq_en(leaveEn), .temp_enter_irq_en(enterEn), .temp_irq_flag_rd(rd),
        .battery_present(1'b1), .charger_input_supply_ok(1'b1), .suspend_req(susp),
        .vbat_above_precond(aboveP), .vbat_at_term(atTerm), .vbat_recharge(rechg),
        .eoc_current(eocCur), .current_ratio(ratio), .charge_indicator_n_oe_b(oeB),
        .charge_indicator_n_out(pinOut), .temp_in_range(inRange), .temp_irq_flag(flag),
        .charge_state(state), .precond_expired(preExp), .total_expired(totExp));
    cts_host_model u_host (.core_clk(core_clk), .temp_irq_flag(flag), .temp_irq_flag_rd(rd));

    // ==========
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_near(input int got, input int exp, input int tol, input string msg);
        checked++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("CHECK FAILED %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic restart(input logic [1:0] p, input logic [1:0] t, input logic a,
                           input logic [15:0] r);
        @(posedge core_clk);
        susp <= 1'b1;
        preSel <= p;
        totSel <= t;
        aboveP <= a;
        ratio <= r;
        step(2);
        @(posedge core_clk);
        susp <= 1'b0;
        step(2);
    endtask
    task automatic wait_exp(input logic tot, output int n);
        n = 0;
        while (((tot ? totExp : preExp) !== 1'b1) && n < 2000) begin
            step(1);
            n++;
        end
    endtask
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========
    // Scenarios
    task automatic test_temp;
        logic v;
        restart(2'h3, 2'h3, 1'b0, 16'h0);
        chk(oeB, 1'b0, "sink");
        @(posedge core_clk);
        hot <= 1'b1;
        leaveEn <= 1'b1;
        step(2);
        chk(inRange, 1'b0, "range hot");
        chk(flag, 1'b1, "leave flag");
        chk(state, 3'h5, "temp fault");
        chk(oeB, 1'b1, "float");
        u_host.read_flag(v);
        chk(v, 1'b1, "read set");
        step(1);
        chk(flag, 1'b0, "cleared");
        @(posedge core_clk);
        hot <= 1'b0;
        leaveEn <= 1'b0;
        step(2);
        chk(inRange, 1'b1, "range ok");
        chk(flag, 1'b0, "enter masked");
        @(posedge core_clk);
        cold <= 1'b1;
        step(2);
        chk(flag, 1'b0, "leave masked");
        chk(state, 3'h5, "cold fault");
        @(posedge core_clk);
        cold <= 1'b0;
        enterEn <= 1'b1;
        step(2);
        chk(flag, 1'b1, "enter flag");
        u_host.read_flag(v);
        u_host.read_flag(v);
        chk(v, 1'b0, "read empty");
    endtask
    task automatic test_topoff;
        @(posedge core_clk);
        hot <= 1'b1;
        restart(2'h3, 2'h3, 1'b1, 16'h0);
        chk(state, 3'h5, "hot start");
        @(posedge core_clk);
        hot <= 1'b0;
        step(3);
        chk(state, 3'h2, "fast");
        chk({oeB, pinOut}, 2'h0, "fast sink");
        @(posedge core_clk);
        atTerm <= 1'b1;
        step(2);
        chk(state, 3'h3, "topoff");
        chk(oeB, 1'b0, "topoff sink");
        @(posedge core_clk);
        eocCur <= 1'b1;
        step(2);
        chk(state, 3'h4, "eoc");
        chk(oeB, 1'b1, "eoc float");
        @(posedge core_clk);
        eocCur <= 1'b0;
        atTerm <= 1'b0;
        rechg <= 1'b1;
        step(2);
        chk(state, 3'h1, "recharge");
        chk(oeB, 1'b0, "recharge sink");
        @(posedge core_clk);
        rechg <= 1'b0;
    endtask
    task automatic test_timers;
        int n;
        for (int s = 0; s < 3; s++) begin
            restart(2'(s), 2'h3, 1'b0, 16'h0);
            wait_exp(1'b0, n);
            chk_near(n, (40 + 20 * s) * MPM * TC, TC + 2, "precond");
            step(1);
            chk(state, 3'h6, "time fault");
            chk(oeB, 1'b1, "fault float");
            restart(2'h3, 2'(s), 1'b1, 16'h0);
            wait_exp(1'b1, n);
            chk_near(n, (3 + s) * 60 * MPM * TC, TC + 2, "total");
            step(1);
            chk(state, 3'h4, "eoc");
            n = 0;
            while (state !== 3'h1 && n < 100) begin
                step(1);
                n++;
            end
            chk_near(n, RT * TC, TC + 2, "relax");
        end
        restart(2'h3, 2'h3, 1'b0, 16'h0);
        step(1300);
        chk(preExp, 1'b0, "pre disabled");
        restart(2'h3, 2'h3, 1'b1, 16'h0);
        step(1300);
        chk({state, totExp}, 4'h4, "tot disabled");
        restart(2'h0, 2'h3, 1'b0, 16'h8000);
        wait_exp(1'b0, n);
        chk_near(n, 80 * MPM * TC, 2 * TC + 4, "stretch");
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        step(1);
        chk({state, oeB, inRange, flag}, 6'h06, "reset");
        test_temp;
        test_topoff;
        test_timers;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        test_done;
    end
endmodule
